/* pkg/fop_pkg.sv */
// constants and shared types for the flag offset loader and its port A host
// assumes one clock (port A clock) shared by both ends
package fop_pkg;
  localparam int OFFSET_W    = 13;
  localparam int DATA_W      = 36;
  localparam int SERIAL_BITS = 52;
  localparam int LOAD_WORDS  = 4;
  // select code is {bit2, select1, select0}
  localparam logic [2:0] SEL_64     = 3'h7;
  localparam logic [2:0] SEL_16     = 3'h6;
  localparam logic [2:0] SEL_8      = 3'h5;
  localparam logic [2:0] SEL_256    = 3'h3;
  localparam logic [2:0] SEL_1024   = 3'h1;
  localparam logic [2:0] SEL_SERIAL = 3'h2;
  localparam logic [2:0] SEL_PAR    = 3'h4;
  localparam logic [2:0] SEL_IP     = 3'h0;
  localparam logic [12:0] PRESET_64   = 13'h0040;
  localparam logic [12:0] PRESET_16   = 13'h0010;
  localparam logic [12:0] PRESET_8    = 13'h0008;
  localparam logic [12:0] PRESET_256  = 13'h0100;
  localparam logic [12:0] PRESET_1024 = 13'h0400;
  localparam logic [12:0] OFFSET_MIN  = 13'h0001;
  localparam logic [12:0] OFFSET_MAX  = 13'h1FFC;
  // interspersed field positions on the port A bus
  localparam int IP_HI_MSB  = 13;
  localparam int IP_HI_LSB  = 9;
  localparam int IP_LO_MSB  = 7;
  localparam int NIP_MSB    = 12;
  localparam logic [2:0] MRS_LOW_CYCLES = 3'h4;
  localparam logic       MAIL2_FLAG_RESET = 1'b1;
  // offset chain, first almost-full on top so an MSB-first serial stream fills it first
  localparam int POS_AF1 = 39;
  localparam int POS_AE1 = 26;
  localparam int POS_AF2 = 13;
  localparam int POS_AE2 = 0;
  typedef enum logic [1:0] {PH_HOLD, PH_SERIAL, PH_PARALLEL, PH_RUN} fop_phase_t;
endpackage

/* pkg/fop_if.sv */
// port A link between the offset loader device and its host
// the shared data bus is resolved here from the two output enables
`timescale 1ns/100ps
`default_nettype none
interface fop_if;
  logic        masterResetFirstN;
  logic        masterResetSecondN;
  logic        flagSelectBit2;
  logic        serialDataSelect0;
  logic        serialEnableSelect1N;
  logic        portaChipSelectN;
  logic        portaWriteReadSelect;
  logic        portaEnable;
  logic        portaMailboxSelect;
  logic [35:0] hostData;
  logic        hostDataOe;
  logic [35:0] devData;
  logic        devDataOe;
  logic [35:0] portaBus;
  logic        portaFullInputReady;
  logic        portbFullInputReady;
  logic        mailboxSecondFlag;
  // undriven bus reads as zero
  assign portaBus = devDataOe ? devData : (hostDataOe ? hostData : 36'h000000000);
  modport dev (
    input  masterResetFirstN, masterResetSecondN, flagSelectBit2, serialDataSelect0,
    input  serialEnableSelect1N, portaChipSelectN, portaWriteReadSelect, portaEnable,
    input  portaMailboxSelect, portaBus,
    output devData, devDataOe, portaFullInputReady, portbFullInputReady, mailboxSecondFlag
  );
  modport host (
    output masterResetFirstN, masterResetSecondN, flagSelectBit2, serialDataSelect0,
    output serialEnableSelect1N, portaChipSelectN, portaWriteReadSelect, portaEnable,
    output portaMailboxSelect, hostData, hostDataOe,
    input  portaBus, portaFullInputReady, portbFullInputReady, mailboxSecondFlag
  );
endinterface
`default_nettype wire

/* hdl/fop_offset_extract.sv */
// picks one offset value out of a port A word
// purely combinational; caller registers the result
`timescale 1ns/100ps
`default_nettype none
module fop_offset_extract (
  input  wire logic [35:0] portData,
  input  wire logic        ipMode,
  output logic      [12:0] offset
);
  always_comb begin
    if (ipMode) begin
      // bit 8 carries parity here and is dropped
      offset = {portData[fop_pkg::IP_HI_MSB:fop_pkg::IP_HI_LSB], portData[fop_pkg::IP_LO_MSB:0]};
    end else begin
      offset = portData[fop_pkg::NIP_MSB:0];
    end
  end
endmodule
`default_nettype wire

/* hdl/fop_device.sv */
// flag offset loader and port A function decode, device end
// assumes host logic on the same clock; master resets are active low levels
`timescale 1ns/100ps
`default_nettype none
module fop_device (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  fop_if.dev               link,
  input  wire logic [35:0] readData,
  input  wire logic        mail2Written,
  output logic      [12:0] almostEmptyOffsetFirst,
  output logic      [12:0] almostFullOffsetFirst,
  output logic      [12:0] almostEmptyOffsetSecond,
  output logic      [12:0] almostFullOffsetSecond,
  output logic             interspersedParityMode,
  output logic             runActive,
  output logic             fifo1Write,
  output logic             mail1Write,
  output logic      [35:0] writeData,
  output logic             fifo2Read,
  output logic             mail2Read
);
  typedef struct packed {
    fop_pkg::fop_phase_t phase;
    logic                ip;
    logic                resetFirstPrev;
    logic                resetSecondPrev;
    logic [51:0]         offs;
    logic [5:0]          bitCnt;
    logic [1:0]          loadIdx;
    logic                ffA;
    logic                ffB;
    logic                mailFlag2;
    logic [35:0]         rdData;
    logic [35:0]         wrData;
    logic                f1Wr;
    logic                m1Wr;
    logic                f2Rd;
    logic                m2Rd;
  } fop_dev_state_t;

  fop_dev_state_t s_q;
  fop_dev_state_t s_d;
  logic [12:0]    busOffset;
  logic [2:0]     code;
  logic           rise1;
  logic           rise2;
  logic           wrFifo;
  logic           wrMail;
  logic           rdFifo;
  logic           rdMail;

  fop_offset_extract u_extract (
    .portData (link.portaBus),
    .ipMode   (s_q.ip),
    .offset   (busOffset)
  );

  assign code   = {link.flagSelectBit2, link.serialEnableSelect1N, link.serialDataSelect0};
  assign rise1  = link.masterResetFirstN & ~s_q.resetFirstPrev;
  assign rise2  = link.masterResetSecondN & ~s_q.resetSecondPrev;
  // table decode of port A, qualified by a rising clock with enable high
  assign wrFifo = ~link.portaChipSelectN & link.portaWriteReadSelect & link.portaEnable
                  & ~link.portaMailboxSelect;
  assign wrMail = ~link.portaChipSelectN & link.portaWriteReadSelect & link.portaEnable
                  & link.portaMailboxSelect;
  assign rdFifo = ~link.portaChipSelectN & ~link.portaWriteReadSelect & link.portaEnable
                  & ~link.portaMailboxSelect;
  assign rdMail = ~link.portaChipSelectN & ~link.portaWriteReadSelect & link.portaEnable
                  & link.portaMailboxSelect;

  always_comb begin
    s_d          = s_q;
    s_d.resetFirstPrev  = link.masterResetFirstN;
    s_d.resetSecondPrev = link.masterResetSecondN;
    s_d.rdData   = readData;
    s_d.wrData   = link.portaBus;
    s_d.f1Wr     = 1'b0;
    s_d.m1Wr     = 1'b0;
    s_d.f2Rd     = 1'b0;
    s_d.m2Rd     = 1'b0;
    if (!link.masterResetFirstN || !link.masterResetSecondN) begin
      s_d.phase = fop_pkg::PH_HOLD;
      if (!link.masterResetFirstN) begin
        s_d.ffA = 1'b0;
      end
      if (!link.masterResetSecondN) begin
        s_d.ffB = 1'b0;
      end
      s_d.mailFlag2 = fop_pkg::MAIL2_FLAG_RESET;
    end else if (rise1 || rise2) begin
      case (code)
        fop_pkg::SEL_64, fop_pkg::SEL_16, fop_pkg::SEL_8, fop_pkg::SEL_256, fop_pkg::SEL_1024: begin
          s_d.phase = fop_pkg::PH_RUN;
          s_d.ip    = 1'b0;
          if (rise1) begin
            s_d.offs[fop_pkg::POS_AF1 +: 13] = presetOf(code);
            s_d.offs[fop_pkg::POS_AE1 +: 13] = presetOf(code);
            s_d.ffA = 1'b1;
          end
          if (rise2) begin
            s_d.offs[fop_pkg::POS_AF2 +: 13] = presetOf(code);
            s_d.offs[fop_pkg::POS_AE2 +: 13] = presetOf(code);
            s_d.ffB = 1'b1;
          end
        end
        fop_pkg::SEL_SERIAL: begin
          // programming methods need both resets rising together
          if (rise1 && rise2) begin
            s_d.phase  = fop_pkg::PH_SERIAL;
            s_d.ip     = 1'b0;
            s_d.bitCnt = 6'h00;
          end
        end
        fop_pkg::SEL_PAR, fop_pkg::SEL_IP: begin
          if (rise1 && rise2) begin
            s_d.phase   = fop_pkg::PH_PARALLEL;
            s_d.ip      = ~link.flagSelectBit2;
            s_d.loadIdx = 2'h0;
            s_d.ffA     = 1'b1;
          end
        end
        default: begin
          s_d.phase = fop_pkg::PH_HOLD;
        end
      endcase
    end else begin
      case (s_q.phase)
        fop_pkg::PH_SERIAL: begin
          // flags rise on the edge after the last bit, not with it
          if (s_q.bitCnt == 6'(fop_pkg::SERIAL_BITS)) begin
            s_d.phase = fop_pkg::PH_RUN;
            s_d.ffA   = 1'b1;
            s_d.ffB   = 1'b1;
          end else if (!link.serialEnableSelect1N) begin
            s_d.offs   = {s_q.offs[50:0], link.serialDataSelect0};
            s_d.bitCnt = s_q.bitCnt + 6'h01;
          end
        end
        fop_pkg::PH_PARALLEL: begin
          if (wrFifo) begin
            s_d.offs[(3 - int'(s_q.loadIdx)) * 13 +: 13] = busOffset;
            s_d.loadIdx = s_q.loadIdx + 2'h1;
            if (s_q.loadIdx == 2'(fop_pkg::LOAD_WORDS - 1)) begin
              s_d.phase = fop_pkg::PH_RUN;
              s_d.ffB   = 1'b1;
            end
          end
        end
        fop_pkg::PH_RUN: begin
          s_d.f1Wr = wrFifo & s_q.ffA;
          s_d.f2Rd = rdFifo;
        end
        default: begin
          s_d.phase = s_q.phase;
        end
      endcase
      // mailboxes stay usable while offsets load
      if (s_q.phase != fop_pkg::PH_HOLD) begin
        s_d.m1Wr = wrMail;
        s_d.m2Rd = rdMail;
        // read sets the flag and wins over a same-cycle port B write
        if (mail2Written) begin
          s_d.mailFlag2 = 1'b0;
        end
        if (rdMail) begin
          s_d.mailFlag2 = 1'b1;
        end
      end
    end
  end

  function automatic logic [12:0] presetOf(input logic [2:0] sel);
    case (sel)
      fop_pkg::SEL_64:   presetOf = fop_pkg::PRESET_64;
      fop_pkg::SEL_16:   presetOf = fop_pkg::PRESET_16;
      fop_pkg::SEL_8:    presetOf = fop_pkg::PRESET_8;
      fop_pkg::SEL_256:  presetOf = fop_pkg::PRESET_256;
      default:           presetOf = fop_pkg::PRESET_1024;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.resetFirstPrev  <= 1'b1;
      s_q.resetSecondPrev <= 1'b1;
      s_q.mailFlag2       <= fop_pkg::MAIL2_FLAG_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign link.devData             = s_q.rdData;
  assign link.devDataOe           = ~link.portaChipSelectN & ~link.portaWriteReadSelect;
  assign link.portaFullInputReady = s_q.ffA;
  assign link.portbFullInputReady = s_q.ffB;
  assign link.mailboxSecondFlag   = s_q.mailFlag2;
  // first pair steers port B empty and port A full, second pair the reverse
  assign almostEmptyOffsetFirst   = s_q.offs[fop_pkg::POS_AE1 +: 13];
  assign almostFullOffsetFirst    = s_q.offs[fop_pkg::POS_AF1 +: 13];
  assign almostEmptyOffsetSecond  = s_q.offs[fop_pkg::POS_AE2 +: 13];
  assign almostFullOffsetSecond   = s_q.offs[fop_pkg::POS_AF2 +: 13];
  assign interspersedParityMode   = s_q.ip;
  assign runActive                = (s_q.phase == fop_pkg::PH_RUN);
  assign fifo1Write               = s_q.f1Wr;
  assign mail1Write               = s_q.m1Wr;
  assign writeData                = s_q.wrData;
  assign fifo2Read                = s_q.f2Rd;
  assign mail2Read                = s_q.m2Rd;
endmodule
`default_nettype wire

/* hdl/fop_host.sv */
// port A host: runs a master reset with a chosen method, loads offsets, does accesses
// assumes the device on the same clock
`timescale 1ns/100ps
`default_nettype none
module fop_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  fop_if.host              link,
  input  wire logic        startReset,
  input  wire logic [2:0]  methodCode,
  input  wire logic [12:0] almostFullOffsetFirst,
  input  wire logic [12:0] almostEmptyOffsetFirst,
  input  wire logic [12:0] almostFullOffsetSecond,
  input  wire logic [12:0] almostEmptyOffsetSecond,
  input  wire logic        accReq,
  input  wire logic        accWrite,
  input  wire logic        accMailbox,
  input  wire logic [35:0] accData,
  output logic             busy,
  output logic             accDone,
  output logic      [35:0] accReadData
);
  typedef enum logic [2:0] {H_IDLE, H_RESET, H_SERIAL, H_PARALLEL, H_ACC, H_CAP} fop_host_phase_t;
  typedef struct packed {
    fop_host_phase_t phase;
    logic [2:0]      code;
    logic [5:0]      cnt;
    logic            mrsN;
    logic [51:0]     offs;
    logic            serBit;
    logic            shiftEnN;
    logic            csn;
    logic            wr;
    logic            en;
    logic            mb;
    logic [35:0]     dOut;
    logic            dOe;
    logic [35:0]     rdData;
    logic            done;
  } fop_host_state_t;

  fop_host_state_t s_q;
  fop_host_state_t s_d;
  logic [12:0]     cur;

  function automatic logic [12:0] clampOff(input logic [12:0] v);
    if (v < fop_pkg::OFFSET_MIN) begin
      clampOff = fop_pkg::OFFSET_MIN;
    end else if (v > fop_pkg::OFFSET_MAX) begin
      clampOff = fop_pkg::OFFSET_MAX;
    end else begin
      clampOff = v;
    end
  endfunction

  assign cur = s_q.offs[51:39];

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.phase)
      H_IDLE: begin
        if (startReset) begin
          s_d.phase = H_RESET;
          s_d.code  = methodCode;
          s_d.serBit   = methodCode[0];
          s_d.shiftEnN = methodCode[1];
          s_d.cnt   = 6'h00;
          s_d.mrsN  = 1'b0;
          s_d.offs  = {clampOff(almostFullOffsetFirst), clampOff(almostEmptyOffsetFirst),
                       clampOff(almostFullOffsetSecond), clampOff(almostEmptyOffsetSecond)};
        end else if (accReq) begin
          s_d.phase = H_ACC;
          s_d.csn   = 1'b0;
          s_d.wr    = accWrite;
          s_d.en    = 1'b1;
          s_d.mb    = accMailbox;
          s_d.dOut  = accData;
          s_d.dOe   = accWrite;
        end
      end
      H_RESET: begin
        s_d.cnt = s_q.cnt + 6'h01;
        if (s_q.cnt[2:0] == fop_pkg::MRS_LOW_CYCLES - 3'h1) begin
          s_d.mrsN = 1'b1; // both resets together
          s_d.cnt  = 6'h00;
          if (s_q.code == fop_pkg::SEL_SERIAL) begin
            s_d.phase = H_SERIAL;
          end else if (s_q.code[1:0] == 2'h0) begin
            s_d.phase = H_PARALLEL;
          end else begin
            s_d.phase = H_IDLE;
          end
        end
      end
      H_SERIAL: begin
        if (s_q.cnt == 6'(fop_pkg::SERIAL_BITS)) begin
          s_d.shiftEnN = 1'b1;
          s_d.phase    = H_IDLE;
        end else begin
          s_d.shiftEnN = 1'b0;
          s_d.serBit   = s_q.offs[51];
          s_d.offs = {s_q.offs[50:0], 1'b0};
          s_d.cnt  = s_q.cnt + 6'h01;
        end
      end
      H_PARALLEL: begin
        if (s_q.cnt == 6'(fop_pkg::LOAD_WORDS)) begin
          s_d.csn   = 1'b1;
          s_d.en    = 1'b0;
          s_d.dOe   = 1'b0;
          s_d.phase = H_IDLE;
        end else begin
          // plain FIFO1 write per offset, first almost-full first
          s_d.csn  = 1'b0;
          s_d.wr   = 1'b1;
          s_d.en   = 1'b1;
          s_d.mb   = 1'b0;
          s_d.dOe  = 1'b1;
          s_d.dOut = 36'h000000000;
          if (s_q.code[2]) begin
            s_d.dOut[fop_pkg::NIP_MSB:0] = cur;
          end else begin
            s_d.dOut[fop_pkg::IP_HI_MSB:fop_pkg::IP_HI_LSB] = cur[12:8];
            s_d.dOut[fop_pkg::IP_LO_MSB:0] = cur[7:0];
            // parity rides in the gap the loader must skip
            s_d.dOut[fop_pkg::IP_LO_MSB + 1] = ^cur;
          end
          s_d.offs = {s_q.offs[38:0], 13'h0000};
          s_d.cnt  = s_q.cnt + 6'h01;
        end
      end
      H_ACC: begin
        s_d.en  = 1'b0;
        s_d.dOe = 1'b0;
        if (s_q.wr) begin
          s_d.csn   = 1'b1;
          s_d.done  = 1'b1;
          s_d.phase = H_IDLE;
        end else begin
          s_d.phase = H_CAP;
        end
      end
      H_CAP: begin
        s_d.rdData = link.portaBus;
        s_d.csn    = 1'b1;
        s_d.done   = 1'b1;
        s_d.phase  = H_IDLE;
      end
      default: begin
        s_d.phase = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q      <= '0;
      s_q.mrsN <= 1'b1;
      s_q.shiftEnN <= 1'b1;
      s_q.csn  <= 1'b1;
      s_q.wr   <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign link.masterResetFirstN    = s_q.mrsN;
  assign link.masterResetSecondN   = s_q.mrsN;
  // select bits stay at the chosen code except when serial, where bit 0 carries the shifted data and bit 1 the shift enable; parallel codes keep 0/1 low
  assign link.flagSelectBit2       = s_q.code[2];
  assign link.serialDataSelect0    = s_q.serBit;
  assign link.serialEnableSelect1N = s_q.shiftEnN;
  assign link.portaChipSelectN     = s_q.csn;
  assign link.portaWriteReadSelect = s_q.wr;
  assign link.portaEnable          = s_q.en;
  assign link.portaMailboxSelect   = s_q.mb;
  assign link.hostData             = s_q.dOut;
  assign link.hostDataOe           = s_q.dOe;
  assign busy                      = (s_q.phase != H_IDLE);
  assign accDone                   = s_q.done;
  assign accReadData               = s_q.rdData;
endmodule
`default_nettype wire

/* tb/fop_properties.sv */
// port A checker for the offset loader and host pair
// assumes the link signals as plain inputs on one clock
`timescale 1ns/100ps
`default_nettype none
module fop_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterResetFirstN,
  input wire logic masterResetSecondN,
  input wire logic flagSelectBit2,
  input wire logic serialDataSelect0,
  input wire logic serialEnableSelect1N,
  input wire logic portaChipSelectN,
  input wire logic portaWriteReadSelect,
  input wire logic portaEnable,
  input wire logic portaMailboxSelect,
  input wire logic devDataOe,
  input wire logic portaFullInputReady,
  input wire logic portbFullInputReady,
  input wire logic mailboxSecondFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] code;
  logic       rise;
  logic       ldWr;
  logic       prev_q;
  logic       serOn_q;
  logic       parOn_q;
  logic [5:0] serCnt_q;
  logic [2:0] ldCnt_q;
  assign code = {flagSelectBit2, serialEnableSelect1N, serialDataSelect0};
  assign rise = masterResetFirstN && masterResetSecondN && !prev_q;
  assign ldWr = !portaChipSelectN && portaWriteReadSelect && portaEnable && !portaMailboxSelect;
  // shadow phase tracking, cleared by the first master reset low
  always_ff @(posedge clk) begin
    prev_q <= rst ? 1'b1 : masterResetFirstN;
    if (rst || !masterResetFirstN) begin
      serOn_q  <= 1'b0;
      parOn_q  <= 1'b0;
      serCnt_q <= 6'h00;
      ldCnt_q  <= 3'h0;
    end else if (rise) begin
      serOn_q  <= (code == fop_pkg::SEL_SERIAL);
      parOn_q  <= (code[1:0] == 2'h0);
      serCnt_q <= 6'h00;
      ldCnt_q  <= 3'h0;
    end else begin
      if (serOn_q && !serialEnableSelect1N && serCnt_q != 6'(fop_pkg::SERIAL_BITS)) begin
        serCnt_q <= serCnt_q + 6'h01;
      end
      if (parOn_q && ldWr && ldCnt_q != 3'(fop_pkg::LOAD_WORDS)) begin
        ldCnt_q <= ldCnt_q + 3'h1;
      end
    end
  end
  a_hold_flags_low: assert property (!masterResetFirstN |=> !portaFullInputReady && !portbFullInputReady)
    else $error("ready flag high in master reset");
  a_preset_ready: assert property (rise && (code inside {3'h7, 3'h6, 3'h5, 3'h3, 3'h1})
    |=> portaFullInputReady && portbFullInputReady) else $error("preset flags not raised");
  a_par_wait: assert property (parOn_q && ldCnt_q != 3'(fop_pkg::LOAD_WORDS)
    |-> portaFullInputReady && !portbFullInputReady) else $error("parallel load flags wrong");
  a_par_ready: assert property (parOn_q && ldCnt_q == 3'(fop_pkg::LOAD_WORDS) |-> portbFullInputReady)
    else $error("port b ready missing after load");
  a_ser_low: assert property (serOn_q && serCnt_q != 6'(fop_pkg::SERIAL_BITS)
    |-> !portaFullInputReady && !portbFullInputReady) else $error("ready flag early in serial load");
  // a new master reset may cut in after the load, so the release is only checked while master reset is high
  a_ser_rise: assert property (serOn_q && serCnt_q == 6'(fop_pkg::SERIAL_BITS) && masterResetFirstN
    |=> portaFullInputReady && portbFullInputReady) else $error("ready flags late after serial load");
  a_bus_drive: assert property (devDataOe == (!portaChipSelectN && !portaWriteReadSelect))
    else $error("port a drive enable wrong");
  a_mail2_flag: assert property (!portaChipSelectN && !portaWriteReadSelect && portaEnable
    && portaMailboxSelect && portbFullInputReady && masterResetFirstN |=> mailboxSecondFlag)
    else $error("mailbox flag not set by read");
  a_reset_low_time: assert property ($fell(masterResetFirstN) |-> !masterResetFirstN[*4] ##1 masterResetFirstN)
    else $error("master reset low time wrong");
  a_reset_pair: assert property (masterResetFirstN == masterResetSecondN)
    else $error("master resets not toggled together");
  a_par_select_low: assert property (parOn_q && masterResetFirstN |-> !serialDataSelect0 && !serialEnableSelect1N)
    else $error("select pins left parallel setting");
endmodule
`default_nettype wire

/* tb/flag_offset_programming_tb_top.sv */
// bench for the offset loader with its port A host facing it
// assumes package, interface and both design modules compiled first
`timescale 1ns/100ps
`default_nettype none
module flag_offset_programming_tb_top;
  logic        clk = 1'b0, rst = 1'b1, startReset = 1'b0, accReq = 1'b0, accWrite = 1'b0;
  logic        accMailbox = 1'b0, mail2Written = 1'b0, busy, accDone, ipMode, runActive;
  logic        fifo1Write, mail1Write, fifo2Read, mail2Read;
  logic [2:0]  methodCode = 3'h7;
  logic [12:0] offs [0:3];
  logic [12:0] aeF, afF, aeS, afS;
  logic [35:0] accData = 36'h000000000, readData = 36'h000000000, accReadData, writeData;
  logic [36:0] expQ [$];
  logic [2:0]  pc [0:4] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
  logic [12:0] pv [0:4] = '{13'h0040, 13'h0010, 13'h0008, 13'h0100, 13'h0400};
  logic [2:0]  mc [0:2] = '{3'h4, 3'h0, 3'h2};
  int          bad_count = 0, n_checks = 0, nRd = 0, nMr = 0;
  integer      seed = 32'h58DF;
  always #2.5 clk = ~clk;
  fop_if bus ();
  fop_device fop_device_inst (.clk(clk), .rst(rst), .ce(1'b1), .link(bus), .readData(readData),
    .mail2Written(mail2Written), .almostEmptyOffsetFirst(aeF), .almostFullOffsetFirst(afF),
    .almostEmptyOffsetSecond(aeS), .almostFullOffsetSecond(afS), .interspersedParityMode(ipMode),
    .runActive(runActive), .fifo1Write(fifo1Write), .mail1Write(mail1Write), .writeData(writeData),
    .fifo2Read(fifo2Read), .mail2Read(mail2Read));
  fop_host fop_host_inst (.clk(clk), .rst(rst), .ce(1'b1), .link(bus), .startReset(startReset),
    .methodCode(methodCode), .almostFullOffsetFirst(offs[0]), .almostEmptyOffsetFirst(offs[1]),
    .almostFullOffsetSecond(offs[2]), .almostEmptyOffsetSecond(offs[3]), .accReq(accReq),
    .accWrite(accWrite), .accMailbox(accMailbox), .accData(accData), .busy(busy), .accDone(accDone),
    .accReadData(accReadData));
  fop_properties fop_properties_inst (.clk(clk), .rst(rst), .masterResetFirstN(bus.masterResetFirstN),
    .masterResetSecondN(bus.masterResetSecondN), .flagSelectBit2(bus.flagSelectBit2),
    .serialDataSelect0(bus.serialDataSelect0), .serialEnableSelect1N(bus.serialEnableSelect1N),
    .portaChipSelectN(bus.portaChipSelectN), .portaWriteReadSelect(bus.portaWriteReadSelect),
    .portaEnable(bus.portaEnable), .portaMailboxSelect(bus.portaMailboxSelect), .devDataOe(bus.devDataOe),
    .portaFullInputReady(bus.portaFullInputReady), .portbFullInputReady(bus.portbFullInputReady),
    .mailboxSecondFlag(bus.mailboxSecondFlag));
  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic waitFor(input int sel);
    int i = 0;
    // sel 0 waits for idle host, else for the access done pulse
    while (sel == 0 ? busy !== 1'b0 : accDone !== 1'b1) begin
      @(negedge clk);
      i++;
      if (i > 500) begin
        bad_count++;
        results();
      end
    end
  endtask
  function automatic logic [35:0] r36();
    return 36'({$random(seed), $random(seed)});
  endfunction
  task automatic mrs(input logic [2:0] code);
    methodCode = code;
    startReset = 1'b1;
    @(negedge clk);
    startReset = 1'b0;
    repeat (2) @(negedge clk);
    waitFor(0);
    repeat (3) @(negedge clk);
  endtask
  task automatic chkOffs(input logic [12:0] af1, ae1, af2, ae2);
    chk({24'h000000, afF}, {24'h000000, af1});
    chk({24'h000000, aeF}, {24'h000000, ae1});
    chk({24'h000000, afS}, {24'h000000, af2});
    chk({24'h000000, aeS}, {24'h000000, ae2});
  endtask
  task automatic acc(input logic w, mb, input logic [35:0] d);
    if (w) expQ.push_back({mb, d});
    accWrite = w;
    accMailbox = mb;
    accData = d;
    accReq = 1'b1;
    @(negedge clk);
    accReq = 1'b0;
    waitFor(1);
    @(negedge clk);
  endtask
  // every write strobe must match the next queued access; loader words never strobe
  always @(posedge clk) begin
    if (fifo2Read === 1'b1) nRd++;
    if (mail2Read === 1'b1) nMr++;
    if (fifo1Write === 1'b1 || mail1Write === 1'b1) begin
      if (expQ.size() == 0) chk({fifo1Write, writeData}, 37'h000000000);
      else chk({mail1Write, writeData}, expQ.pop_front());
    end
  end
  initial begin
    foreach (offs[j]) offs[j] = 13'h0001;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (pc[k]) begin
      mrs(pc[k]);
      chkOffs(pv[k], pv[k], pv[k], pv[k]);
    end
    foreach (mc[k]) begin
      foreach (offs[j]) offs[j] = 13'((($random(seed) & 32'h7FFFFFFF) % 8188) + 1);
      mrs(mc[k]);
      chkOffs(offs[0], offs[1], offs[2], offs[3]);
      chk({36'h000000000, ipMode}, {36'h000000000, mc[k] == 3'h0});
      chk({36'h000000000, runActive}, 37'h000000001);
      acc(1'b1, 1'b0, r36());
    end
    readData = r36();
    acc(1'b1, 1'b1, r36());
    mail2Written = 1'b1;
    @(negedge clk);
    mail2Written = 1'b0;
    @(negedge clk);
    chk({36'h000000000, bus.mailboxSecondFlag}, 37'h000000000);
    acc(1'b0, 1'b1, 36'h000000000);
    chk({1'b0, accReadData}, {1'b0, readData});
    chk({36'h000000000, bus.mailboxSecondFlag}, 37'h000000001);
    acc(1'b0, 1'b0, 36'h000000000);
    chk(37'(nRd), 37'h000000001);
    chk(37'(nMr), 37'h000000001);
    chk(37'(expQ.size()), 37'h000000000);
    results();
  end
endmodule
`default_nettype wire
